// ==== core/sww_sleep_wdt.sv ====
// sleep entry, wake-up sequencing and keyed watchdog control
// assumes CLK is the system clock; pins and the low-speed clock are async
//
// Contract
// - only the sleep instruction enters sleep, stopping oscillator
// - in sleep all registers and pin states are kept
// - sleep instruction clears the watchdog counter; a low-speed-clocked counter keeps counting
// - sleep instruction sets power-down flag, clears timeout flag
// - wake on external reset, enabled port falling edge, interrupt, overflow
// - reset wake is full reset; overflow wake sets timeout, clears pc/sp
// - power-down flag cleared by power-up or clear-watchdog, set by sleep
// - enabled port pin falling edge wakes; resume after sleep instruction
// - disabled interrupt or full stack: resume, request stays pending
// - enabled interrupt with stack room: normal interrupt response
// - interrupt already requested before sleep does not wake
// - wake delay is 16 clocks, plus reset delay for external reset
// - timeout is 2^(8+code) source cycles, reset code 111
// - clock select 00 low-speed, 01 system/4, 10 and 11 system
// - key 000000 enables, 101101 disables, others reset the part
// - a bad key resets after two to three low-speed clock periods
// - system-clocked watchdog stops during sleep
// - overflow in normal operation resets and sets timeout flag
// - counter cleared by bad key, reset pin, clear-watchdog, sleep
// - with watchdog disabled clear-watchdog is a no-operation
`timescale 1ns/1ps
module sww_sleep_wdt #(
   parameter int IRQ_W = 4,
   parameter int RESET_DELAY_CYC = sww_pkg::RSTD_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // register port
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [7:0] RDATA,
   // instruction events from the core
   input wire logic HALT_EXEC,
   input wire logic CLRWDT_EXEC,
   // pins
   input wire logic RES_N,
   input wire logic [3:0] PA_PIN,
   input wire logic SLOW_CLK,
   // interrupt controller
   input wire logic [IRQ_W-1:0] IRQ_REQ,
   input wire logic [IRQ_W-1:0] IRQ_EN,
   input wire logic STACK_FULL,
   // system control
   output logic OSC_RUN,
   output logic CPU_HOLD,
   output logic SYS_RST,
   output logic PCSP_CLR,
   output logic INT_SERVICE,
   output logic TIMEOUT_FLAG,
   output logic POWER_DOWN_FLAG,
   output logic WDT_ON
);
   if (IRQ_W < 1 || IRQ_W > 8) begin : g_bad_irq
      $error("IRQ_W must lie in 1..8");
   end
   if (RESET_DELAY_CYC < 1 || RESET_DELAY_CYC >= (1 << sww_pkg::DLY_W))
   begin : g_bad_dly
      $error("RESET_DELAY_CYC does not fit the delay counter");
   end

   typedef struct packed {
      sww_pkg::sww_state_e st;
      sww_pkg::sww_src_e src;
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] s3;
      logic [5:0] filt;
      logic [2:0] tsel;
      logic [7:0] ctrl;
      logic [3:0] wake_en;
      logic to;
      logic pdn;
      logic [IRQ_W-1:0] irq_pre;
      logic [IRQ_W-1:0] woke;
      logic [sww_pkg::DLY_W-1:0] cnt;
      logic [1:0] kb;
      logic [7:0] rdata;
      logic osc;
      logic hold;
      logic rst;
      logic pcsp;
      logic isvc;
      logic won;
   } sww_core_s;

   localparam logic [sww_pkg::DLY_W-1:0] RSTD_LAST =
      sww_pkg::DLY_W'(RESET_DELAY_CYC - 1);
   localparam logic [sww_pkg::DLY_W-1:0] SST_LAST =
      sww_pkg::DLY_W'(sww_pkg::SST_CYC - 1);

   sww_core_s r_reg;
   sww_core_s r_next;
   logic [5:0] filt_d;
   logic slow_tick;
   logic [3:0] pa_fall;
   logic res_low;
   logic [5:0] key;
   logic key_on;
   logic key_bad;
   logic kb_fire;
   logic halt_go;
   logic clr_ok;
   logic wd_clear;
   logic wd_ovf;
   logic pa_wake;
   logic [IRQ_W-1:0] irq_new;

   // a lane changes only once the second and third stages agree
   for (genvar g = 0; g < sww_pkg::SYNC_W; g++) begin : g_flt
      assign filt_d[g] = (r_reg.s2[g] == r_reg.s3[g]) ?
         r_reg.s2[g] : r_reg.filt[g];
   end

   assign slow_tick = filt_d[sww_pkg::LANE_SLOW] &
      ~r_reg.filt[sww_pkg::LANE_SLOW];
   assign pa_fall = r_reg.filt[3:0] & ~filt_d[3:0];
   assign res_low = ~r_reg.filt[sww_pkg::LANE_RES];
   assign key = r_reg.ctrl[sww_pkg::KEY_HI:0];
   assign key_on = key == sww_pkg::KEY_ON;
   assign key_bad = !key_on && key != sww_pkg::KEY_OFF;
   assign kb_fire = key_bad && r_reg.kb == sww_pkg::KEY_RST_TICKS;
   assign halt_go = HALT_EXEC && r_reg.st == sww_pkg::ST_RUN;
   // clear-watchdog does nothing while the watchdog is off
   assign clr_ok = CLRWDT_EXEC && key_on &&
      r_reg.st == sww_pkg::ST_RUN;
   assign wd_clear = halt_go || clr_ok ||
      r_reg.st == sww_pkg::ST_RESET;
   assign pa_wake = |(pa_fall & r_reg.wake_en);
   // requests already raised at sleep entry are not wake sources
   assign irq_new = IRQ_REQ & ~r_reg.irq_pre;

   sww_wdt_core u_wdt (
      .clk(CLK),
      .srst(SRST),
      .clear(wd_clear),
      .enable(key_on),
      .sys_run(r_reg.osc),
      .slow_tick(slow_tick),
      .clk_sel(r_reg.ctrl[sww_pkg::CLS_HI:sww_pkg::CLS_LO]),
      .tsel(r_reg.tsel),
      .overflow(wd_ovf)
   );

   always_comb begin
      r_next = r_reg;
      r_next.s1 = {SLOW_CLK, RES_N, PA_PIN};
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      r_next.filt = filt_d;
      r_next.rdata = 8'h00;
      r_next.pcsp = 1'b0;
      r_next.isvc = 1'b0;

      // read data stand only in the cycle after the strobe
      if (RD_STB) begin
         case (ADDR)
            sww_pkg::ADR_TSEL: r_next.rdata = {5'h00, r_reg.tsel};
            sww_pkg::ADR_CTRL: r_next.rdata = r_reg.ctrl;
            sww_pkg::ADR_STAT: r_next.rdata = {2'h0, r_reg.to, r_reg.pdn,
               4'h0};
            sww_pkg::ADR_WAKE: r_next.rdata = {4'h0, r_reg.wake_en};
            default: r_next.rdata = 8'h00;
         endcase
      end

      // count low-speed periods while the key holds a bad value
      if (!key_bad) begin
         r_next.kb = 2'h0;
      end else if (slow_tick && r_reg.kb != sww_pkg::KEY_RST_TICKS) begin
         r_next.kb = r_reg.kb + 2'h1;
      end

      case (r_reg.st)
         sww_pkg::ST_RUN: begin
            if (WR_STB) begin
               case (ADDR)
                  sww_pkg::ADR_TSEL: r_next.tsel = WDATA[2:0];
                  sww_pkg::ADR_CTRL: r_next.ctrl = WDATA;
                  sww_pkg::ADR_STAT: begin
                     r_next.to = WDATA[sww_pkg::STAT_TO_BIT];
                     r_next.pdn = WDATA[sww_pkg::STAT_PDN_BIT];
                  end
                  sww_pkg::ADR_WAKE: r_next.wake_en = WDATA[3:0];
                  default: r_next.wake_en = r_reg.wake_en;
               endcase
            end
            // hardware updates follow the write so that they win
            if (clr_ok) begin
               r_next.pdn = 1'b0;
               r_next.to = 1'b0;
            end
            if (halt_go) begin
               r_next.pdn = 1'b1;
               r_next.to = 1'b0;
               r_next.irq_pre = IRQ_REQ;
               r_next.st = sww_pkg::ST_SLEEP;
            end
         end
         sww_pkg::ST_SLEEP: begin
            // register writes are ignored; all state is held
            if (wd_ovf) begin
               r_next.to = 1'b1;
               r_next.src = sww_pkg::SRC_WDT;
               r_next.st = sww_pkg::ST_WAKE;
               r_next.cnt = '0;
            end else if (pa_wake) begin
               r_next.src = sww_pkg::SRC_PORT;
               r_next.st = sww_pkg::ST_WAKE;
               r_next.cnt = '0;
            end else if (|irq_new) begin
               r_next.src = sww_pkg::SRC_IRQ;
               r_next.woke = irq_new;
               r_next.st = sww_pkg::ST_WAKE;
               r_next.cnt = '0;
            end
         end
         sww_pkg::ST_WAKE: begin
            // start-up delay before execution resumes
            if (r_reg.cnt == SST_LAST) begin
               r_next.st = sww_pkg::ST_RUN;
               r_next.cnt = '0;
               r_next.pcsp = r_reg.src == sww_pkg::SRC_WDT;
               // a held-off request stays pending in the controller
               r_next.isvc = r_reg.src == sww_pkg::SRC_IRQ &&
                  |(r_reg.woke & IRQ_EN) && !STACK_FULL;
            end else begin
               r_next.cnt = r_reg.cnt + 21'h1;
            end
         end
         sww_pkg::ST_RESET: begin
            // full reset returns control registers to their reset values
            r_next.tsel = sww_pkg::TSEL_RST;
            r_next.ctrl = sww_pkg::CTRL_RST;
            r_next.wake_en = sww_pkg::WAKE_RST;
            r_next.irq_pre = '0;
            if (res_low) begin
               r_next.cnt = '0;
            end else if (r_reg.cnt == RSTD_LAST) begin
               r_next.st = sww_pkg::ST_WAKE;
               r_next.src = sww_pkg::SRC_RES;
               r_next.cnt = '0;
            end else begin
               r_next.cnt = r_reg.cnt + 21'h1;
            end
         end
         default: begin
            r_next.st = sww_pkg::ST_RUN;
         end
      endcase

      // reset pin and bad key override every state; watchdog overflow resets only from run or wake
      if (res_low || kb_fire) begin
         r_next.st = sww_pkg::ST_RESET;
         r_next.cnt = '0;
      end else if (wd_ovf && r_reg.st != sww_pkg::ST_SLEEP &&
         r_reg.st != sww_pkg::ST_RESET) begin
         r_next.to = 1'b1;
         r_next.st = sww_pkg::ST_RESET;
         r_next.cnt = '0;
      end

      r_next.osc = r_next.st != sww_pkg::ST_SLEEP;
      r_next.hold = r_next.st != sww_pkg::ST_RUN;
      r_next.rst = r_next.st == sww_pkg::ST_RESET;
      r_next.won = r_next.ctrl[sww_pkg::KEY_HI:0] == sww_pkg::KEY_ON;
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         r_reg <= '0;
         r_reg.st <= sww_pkg::ST_RUN;
         r_reg.src <= sww_pkg::SRC_PORT;
         r_reg.s1 <= sww_pkg::SYNC_RST;
         r_reg.s2 <= sww_pkg::SYNC_RST;
         r_reg.s3 <= sww_pkg::SYNC_RST;
         r_reg.filt <= sww_pkg::SYNC_RST;
         r_reg.tsel <= sww_pkg::TSEL_RST;
         r_reg.ctrl <= sww_pkg::CTRL_RST;
         r_reg.wake_en <= sww_pkg::WAKE_RST;
         r_reg.osc <= 1'b1;
         r_reg.won <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign RDATA = r_reg.rdata;
   assign OSC_RUN = r_reg.osc;
   assign CPU_HOLD = r_reg.hold;
   assign SYS_RST = r_reg.rst;
   assign PCSP_CLR = r_reg.pcsp;
   assign INT_SERVICE = r_reg.isvc;
   assign TIMEOUT_FLAG = r_reg.to;
   assign POWER_DOWN_FLAG = r_reg.pdn;
   assign WDT_ON = r_reg.won;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   sleep_entry_a: assert property (
      halt_go && !res_low && !kb_fire && !wd_ovf
      |=> !OSC_RUN && CPU_HOLD && r_reg.st == sww_pkg::ST_SLEEP)
      else $error("sleep instruction did not stop the oscillator");

   halt_flags_a: assert property (
      halt_go && !res_low && !kb_fire && !wd_ovf
      |=> POWER_DOWN_FLAG && !TIMEOUT_FLAG)
      else $error("sleep instruction left the status flags wrong");

   sleep_hold_a: assert property (
      r_reg.st == sww_pkg::ST_SLEEP && !res_low && !kb_fire
      |=> $stable(r_reg.tsel) && $stable(r_reg.ctrl)
         && $stable(r_reg.wake_en)
         && $stable(POWER_DOWN_FLAG))
      else $error("register contents changed during sleep");

   wake_delay_a: assert property (
      r_reg.st == sww_pkg::ST_SLEEP ##1 r_reg.st == sww_pkg::ST_WAKE
      && !res_low && !kb_fire
      |-> ##15 (r_reg.st == sww_pkg::ST_WAKE && CPU_HOLD) ##1 !CPU_HOLD)
      else $error("start-up delay after wake is not 16 clocks");

   port_wake_a: assert property (
      r_reg.st == sww_pkg::ST_SLEEP && pa_wake && !wd_ovf && !res_low
      && !kb_fire
      |=> r_reg.st == sww_pkg::ST_WAKE && r_reg.src == sww_pkg::SRC_PORT)
      else $error("enabled port falling edge did not wake");

   stale_irq_a: assert property (
      r_reg.st == sww_pkg::ST_SLEEP && irq_new == '0 && !pa_wake
      && !wd_ovf && !res_low && !kb_fire
      |=> r_reg.st == sww_pkg::ST_SLEEP)
      else $error("sleep left without a fresh wake source");

   run_ovf_a: assert property (
      r_reg.st == sww_pkg::ST_RUN && wd_ovf && !res_low
      |=> SYS_RST && TIMEOUT_FLAG)
      else $error("overflow in normal operation did not reset");

   key_early_a: assert property (
      key_bad && r_reg.kb != sww_pkg::KEY_RST_TICKS
      && r_reg.st == sww_pkg::ST_RUN && !res_low && !wd_ovf
      |=> !SYS_RST)
      else $error("bad key reset came before three low-speed edges");

   key_reset_a: assert property (
      kb_fire |=> SYS_RST ##1 !key_bad)
      else $error("bad key did not force a reset");

   clr_nop_a: assert property (
      CLRWDT_EXEC && !key_on && r_reg.st == sww_pkg::ST_RUN
      && !HALT_EXEC && !WR_STB && !res_low && !kb_fire && !wd_ovf
      |=> $stable(POWER_DOWN_FLAG) && $stable(TIMEOUT_FLAG))
      else $error("clear-watchdog acted while the watchdog was off");
endmodule : sww_sleep_wdt

// ==== core/sww_pkg.sv ====
// constants and types shared by the sleep/wake and watchdog block
// assumes a single 20 MHz system clock that also paces the core
package sww_pkg;
   // register addresses on the plain register port
   localparam logic [2:0] ADR_TSEL = 3'h0;
   localparam logic [2:0] ADR_CTRL = 3'h1;
   localparam logic [2:0] ADR_STAT = 3'h2;
   localparam logic [2:0] ADR_WAKE = 3'h3;
   // reset values
   localparam logic [2:0] TSEL_RST = 3'h7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] WAKE_RST = 4'h0;
   // field positions
   localparam int STAT_TO_BIT = 5;
   localparam int STAT_PDN_BIT = 4;
   localparam int CLS_HI = 7;
   localparam int CLS_LO = 6;
   localparam int KEY_HI = 5;
   // key field codes
   localparam logic [5:0] KEY_ON = 6'h00;
   localparam logic [5:0] KEY_OFF = 6'h2d;
   // watchdog clock select codes
   localparam logic [1:0] CLS_SLOW = 2'h0;
   localparam logic [1:0] CLS_DIV4 = 2'h1;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   // watchdog counter
   localparam int WD_W = 15;
   localparam logic [14:0] WD_FULL = 15'h7fff;
   // low-speed clock periods before a bad key resets the part
   localparam logic [1:0] KEY_RST_TICKS = 2'h3;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int RSTD_MS = 50;
   localparam int RSTD_CYC = RSTD_MS * (CLK_HZ / 1000);
   localparam int SST_TSYS = 16;
   localparam int SST_CYC = SST_TSYS;
   localparam int DLY_W = 21;
   // synchroniser lanes: 0..3 port pins, 4 reset pin, 5 low-speed clock
   localparam int SYNC_W = 6;
   localparam int LANE_RES = 4;
   localparam int LANE_SLOW = 5;
   localparam logic [5:0] SYNC_RST = 6'h1f;

   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_SLEEP = 2'h1,
      ST_WAKE = 2'h3,
      ST_RESET = 2'h2
   } sww_state_e;

   typedef enum logic [1:0] {
      SRC_PORT = 2'h0,
      SRC_IRQ = 2'h1,
      SRC_WDT = 2'h2,
      SRC_RES = 2'h3
   } sww_src_e;
endpackage : sww_pkg

// ==== core/sww_wdt_core.sv ====
// watchdog counter with clock source selection and timeout tap
// assumes slow_tick is a one-cycle pulse already synchronised to clk
`timescale 1ns/1ps
module sww_wdt_core (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // control
   input wire logic clear,
   input wire logic enable,
   input wire logic sys_run,
   input wire logic slow_tick,
   input wire logic [1:0] clk_sel,
   input wire logic [2:0] tsel,
   // event
   output logic overflow
);
   typedef struct packed {
      logic [1:0] div;
      logic [14:0] cnt;
      logic ovf;
   } sww_wd_s;

   sww_wd_s st_reg;
   sww_wd_s st_next;
   logic tick;
   logic [14:0] lim;

   always_comb begin
      st_next = st_reg;
      st_next.ovf = 1'b0;
      // system-derived sources freeze while the oscillator is stopped
      case (clk_sel)
         sww_pkg::CLS_SLOW: tick = slow_tick;
         sww_pkg::CLS_DIV4: tick = sys_run && st_reg.div == sww_pkg::DIV4_LAST;
         default: tick = sys_run;
      endcase
      if (sys_run) begin
         st_next.div = st_reg.div + 2'h1;
      end
      // timeout of 2^(8+tsel) source cycles
      lim = sww_pkg::WD_FULL >> (3'h7 - tsel);
      if (clear) begin
         st_next.cnt = '0;
      end else if (enable && tick) begin
         if ((st_reg.cnt & lim) == lim) begin
            st_next.cnt = '0;
            st_next.ovf = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 15'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign overflow = st_reg.ovf;

   ovf_gap_a: assert property (@(posedge clk) disable iff (srst)
      overflow |=> !overflow)
      else $error("watchdog overflow repeated on back-to-back cycles");
endmodule : sww_wdt_core

// ==== test/tb.sv ====
// self-checking bench for the sleep/wake and keyed watchdog block
// assumes the block's register map and reset delay parameter as declared
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
   localparam int RDLY = 20;
   localparam logic [2:0] A_TSEL = 3'h0;
   localparam logic [2:0] A_CTL = 3'h1;
   localparam logic [2:0] A_WAKE = 3'h3;
   logic clk, srst, wr_stb, rd_stb, halt_exec, clrwdt_exec, res_n, slow_clk;
   logic stack_full, osc_run, cpu_hold, sys_rst, pcsp_clr, int_service;
   logic timeout_flag, power_down_flag, wdt_on;
   logic [2:0] addr;
   logic [7:0] wdata, rdata;
   logic [3:0] pa_pin, irq_req, irq_en;
   int fail_count, checked, slow_cnt, n, hold;
   logic svc, pc;
   // behavioural register and flag model
   logic [2:0] m_tsel;
   logic [7:0] m_ctl;
   logic [3:0] m_wake;
   logic m_to, m_pdn;
   int tbl [3][3] = '{'{2, 0, 256}, '{3, 1, 512}, '{1, 0, 1024}};

   sww_sleep_wdt #(.IRQ_W(4), .RESET_DELAY_CYC(RDLY)) sww_sleep_wdt_i (
      .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
      .RD_STB(rd_stb), .RDATA(rdata), .HALT_EXEC(halt_exec),
      .CLRWDT_EXEC(clrwdt_exec), .RES_N(res_n), .PA_PIN(pa_pin),
      .SLOW_CLK(slow_clk), .IRQ_REQ(irq_req), .IRQ_EN(irq_en),
      .STACK_FULL(stack_full), .OSC_RUN(osc_run), .CPU_HOLD(cpu_hold),
      .SYS_RST(sys_rst), .PCSP_CLR(pcsp_clr), .INT_SERVICE(int_service),
      .TIMEOUT_FLAG(timeout_flag), .POWER_DOWN_FLAG(power_down_flag),
      .WDT_ON(wdt_on));

   initial clk = 1'b0;
   always #25 clk = ~clk;
   // low-speed clock, period 40 system clocks
   always @(posedge clk) begin
      slow_cnt <= (slow_cnt == 19) ? 0 : slow_cnt + 1;
      if (slow_cnt == 19) slow_clk <= ~slow_clk;
   end

   function automatic logic [7:0] m_read(input logic [2:0] a);
      case (a)
         A_TSEL: return {5'h00, m_tsel};
         A_CTL: return m_ctl;
         sww_pkg::ADR_STAT: return {2'h0, m_to, m_pdn, 4'h0};
         A_WAKE: return {4'h0, m_wake};
         default: return 8'h00;
      endcase
   endfunction : m_read

   task automatic m_reset();
      m_tsel = 3'h7;
      m_ctl = 8'h00;
      m_wake = 4'h0;
   endtask : m_reset

   // writes land only while the core runs
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic busy;
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      #1;
      busy = cpu_hold;
      @(posedge clk);
      wr_stb <= 1'b0;
      if (!busy) begin
         case (a)
            A_TSEL: m_tsel = d[2:0];
            A_CTL: m_ctl = d;
            sww_pkg::ADR_STAT: {m_to, m_pdn} = d[5:4];
            A_WAKE: m_wake = d[3:0];
            default: ;
         endcase
      end
   endtask : wr

   task automatic rd_chk(input logic [2:0] a);
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      `CHK(rdata, m_read(a))
   endtask : rd_chk

   task automatic pulse(input int which);
      @(posedge clk);
      if (which == 0) halt_exec <= 1'b1;
      else clrwdt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      clrwdt_exec <= 1'b0;
   endtask : pulse

   task automatic sleep_now();
      pulse(0);
      m_pdn = 1'b1;
      m_to = 1'b0;
      #1;
      `CHK({osc_run, cpu_hold}, 2'b01)
      `CHK({timeout_flag, power_down_flag}, 2'b01)
   endtask : sleep_now

   task automatic wait_on(input int w, input int lim, output int k);
      k = 0;
      while (!((w == 0 && osc_run === 1'b1) || (w == 1 && sys_rst === 1'b1)
            || (w == 2 && cpu_hold === 1'b0)) && k < lim) begin
         @(posedge clk);
         #1;
         k++;
      end
      `CHK(k < lim, 1'b1)
   endtask : wait_on

   // counts hold cycles from the first wake cycle and notes end pulses
   task automatic wake_seq();
      hold = 0;
      svc = 1'b0;
      pc = 1'b0;
      while (cpu_hold === 1'b1 && hold < 40) begin
         hold++;
         @(posedge clk);
         #1;
         svc |= int_service;
         pc |= pcsp_clr;
      end
      `CHK(hold, 16)
   endtask : wake_seq

   task automatic after_rst();
      wait_on(2, 300, n);
      m_reset();
      `CHK(sys_rst, 1'b0)
   endtask : after_rst

   task automatic give_verdict();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   initial begin
      #2_000_000;
      fail_count++;
      give_verdict();
   end

   initial begin
      {wr_stb, rd_stb, halt_exec, clrwdt_exec, stack_full, slow_clk} = '0;
      {addr, wdata, irq_req, irq_en, slow_cnt, fail_count, checked} = '0;
      res_n = 1'b1;
      pa_pin = 4'hf;
      srst = 1'b1;
      m_reset();
      {m_to, m_pdn} = 2'b00;
      void'($urandom(34));
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 5; a++) rd_chk(3'(a));
      `CHK(wdt_on, 1'b1)
      wr(A_TSEL, 8'($urandom));
      wr(A_WAKE, 8'($urandom));
      rd_chk(A_TSEL);
      rd_chk(A_WAKE);
      // system-clocked watchdog holds in sleep; only enabled pins wake
      wr(A_WAKE, 8'h01);
      wr(A_TSEL, 8'h00);
      wr(A_CTL, 8'h80);
      irq_req <= 4'h1;
      irq_en <= 4'h1;
      sleep_now();
      pa_pin <= 4'hd;
      repeat (600) @(posedge clk);
      #1;
      `CHK({osc_run, sys_rst}, 2'b00)
      wr(A_CTL, 8'h00);
      rd_chk(A_CTL);
      pa_pin <= 4'hc;
      wait_on(0, 20, n);
      wake_seq();
      {pa_pin, irq_req} <= 8'hf0;
      wr(A_CTL, 8'h00);
      rd_chk(sww_pkg::ADR_STAT);
      // interrupt wakes: serviced, disabled, stack full
      for (int i = 0; i < 3; i++) begin
         irq_en <= (i == 1) ? 4'h0 : 4'h4;
         stack_full <= (i == 2);
         sleep_now();
         irq_req <= 4'h4;
         wait_on(0, 20, n);
         wake_seq();
         `CHK(svc, i == 0)
         irq_req <= 4'h0;
      end
      pulse(1);
      m_pdn = 1'b0;
      m_to = 1'b0;
      rd_chk(sww_pkg::ADR_STAT);
      // overflow in run, system and system/4 clock sources, codes 0 and 1
      for (int i = 0; i < 3; i++) begin
         wr(A_TSEL, 8'(tbl[i][1]));
         wr(A_CTL, 8'(tbl[i][0] << 6));
         pulse(1);
         wait_on(1, 3000, n);
         `CHK(n >= tbl[i][2] - 2 && n <= tbl[i][2] + 8, 1'b1)
         `CHK(timeout_flag, 1'b1)
         m_to = 1'b1;
         after_rst();
         rd_chk(A_CTL);
         rd_chk(A_TSEL);
      end
      // regular clearing keeps it alive
      wr(A_TSEL, 8'h00);
      wr(A_CTL, 8'h80);
      for (int i = 0; i < 5; i++) begin
         pulse(1);
         repeat (200) @(posedge clk);
         #1;
         `CHK(sys_rst, 1'b0)
      end
      // disabled watchdog ignores clear and never fires
      wr(A_CTL, 8'h80 | sww_pkg::KEY_OFF);
      wr(sww_pkg::ADR_STAT, 8'h10);
      pulse(1);
      #1;
      `CHK(wdt_on, 1'b0)
      rd_chk(sww_pkg::ADR_STAT);
      repeat (600) @(posedge clk);
      #1;
      `CHK(sys_rst, 1'b0)
      // invalid key resets after two to three low-speed periods
      wr(A_CTL, 8'h15);
      wait_on(1, 300, n);
      `CHK(n >= 70 && n <= 135, 1'b1)
      after_rst();
      // low-speed watchdog wakes from sleep
      wr(A_TSEL, 8'h00);
      sleep_now();
      wait_on(0, 11000, n);
      `CHK(n >= 10100 && n <= 10400, 1'b1)
      `CHK(timeout_flag, 1'b1)
      m_to = 1'b1;
      wake_seq();
      `CHK({pc, sys_rst}, 2'b10)
      rd_chk(A_TSEL);
      rd_chk(sww_pkg::ADR_STAT);
      // external reset wakes with a full reset
      sleep_now();
      res_n <= 1'b0;
      wait_on(1, 10, n);
      repeat (5) @(posedge clk);
      res_n <= 1'b1;
      after_rst();
      rd_chk(A_TSEL);
      give_verdict();
   end
endmodule : tb
